// ===== src/iotc_consts.svh
// Offsets, field positions and timing for the I/O bus control
`ifndef IOTC_CONSTS_SVH
`define IOTC_CONSTS_SVH

// Register offsets (byte addresses, one word each)
`define IOTC_OFS_CMD        8'h00
`define IOTC_OFS_INSTR      8'h04
`define IOTC_OFS_DATA_OUT   8'h08
`define IOTC_OFS_DATA_IN    8'h0c
`define IOTC_OFS_STATUS     8'h10
`define IOTC_OFS_DISPATCH   8'h14

// Command word: condition field bit and magic number field
`define IOTC_CMD_COND_BIT   15
`define IOTC_CMD_MAGIC_MSB  8
`define IOTC_CMD_MAGIC_LSB  0

// Magic numbers that go with the bus control condition function
`define IOTC_MAGIC_REQUEST  9'h100
`define IOTC_MAGIC_RELEASE  9'h0c0
`define IOTC_MAGIC_ACQ_ECL  9'h001
`define IOTC_MAGIC_REL_ECL  9'h002
`define IOTC_MAGIC_DOUT     9'h014
`define IOTC_MAGIC_DIN      9'h018

// Function codes forced by the stand-alone data suboperations
`define IOTC_FUNC_DOUT      3'h3
`define IOTC_FUNC_DIN       3'h1

// Upper dispatch address bits for the I/O opcode group
`define IOTC_DISP_TOP       3'h7

// Status bit positions
`define IOTC_ST_CPU_GRANT   0
`define IOTC_ST_IRQ_GRANT   1
`define IOTC_ST_DEMAND      2
`define IOTC_ST_BUSY        3
`define IOTC_ST_ECL_HELD    4
`define IOTC_ST_DONE        5

// Timing
`define IOTC_CLK_MHZ        100
`define IOTC_SETUP_NS       300
`define IOTC_DEMAND_NS      300
`define IOTC_HOLD_NS        100

`endif

// ===== src/iotc_pkg.sv
// Types shared by the I/O bus transfer control
package iotc_pkg;

  // Control lines driven onto the system I/O bus
  typedef struct packed {
    logic [6:0] controller_select_lines;
    logic       function_line_0;
    logic       function_line_1;
    logic       function_line_2;
    logic       demand;
  } iotc_bus_ctl_t;

  // Transfer sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WAIT   = 3'b001,
    ST_SETUP  = 3'b010,
    ST_DEMAND = 3'b011,
    ST_XFER   = 3'b100,
    ST_DROP   = 3'b101,
    ST_DONE   = 3'b110
  } iotc_state_t;

endpackage : iotc_pkg

// ===== src/iotc_io_bus_ctl.sv
// I/O bus transfer control: arbiter, sequencer, decode and register port
`timescale 1ns/1ns
`include "iotc_consts.svh"

module iotc_io_bus_ctl #(
  parameter int DATA_W = 36
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  srst_i,
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [DATA_W-1:0]     reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output      logic [DATA_W-1:0]     reg_rdata_o,
  input  wire logic                  interrupt_bus_request_i,
  output      logic                  interrupt_bus_grant_o,
  output      logic                  processor_bus_request_o,
  output      logic                  processor_bus_grant_o,
  output      logic                  bus_return_o,
  output      iotc_pkg::iotc_bus_ctl_t bus_ctl_o,
  input  wire logic                  transfer_i,
  input  wire logic [DATA_W-1:0]     data_i,
  output      logic [DATA_W-1:0]     data_o,
  output      logic                  data_oe_o
);

  // Cycle counts rounded up from the minimum times
  localparam int SETUP_CYC  =
    (`IOTC_SETUP_NS * `IOTC_CLK_MHZ + 999) / 1000;
  localparam int DEMAND_CYC =
    (`IOTC_DEMAND_NS * `IOTC_CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC   =
    (`IOTC_HOLD_NS * `IOTC_CLK_MHZ + 999) / 1000;

  // Command decode
  logic       cmd_wr;
  logic       cond_fn;
  logic [8:0] magic;
  logic       cmd_request;
  logic       cmd_release;
  logic       cmd_acq_ecl;
  logic       cmd_rel_ecl;
  logic       cmd_data_out;
  logic       cmd_data_in;

  // A command only counts when condition and magic come in one write
  assign cmd_wr       = reg_wr_i && (reg_addr_i == `IOTC_OFS_CMD) && cond_fn;
  assign cond_fn      = reg_wdata_i[`IOTC_CMD_COND_BIT];
  assign magic        = reg_wdata_i[`IOTC_CMD_MAGIC_MSB:`IOTC_CMD_MAGIC_LSB];
  assign cmd_request  = cmd_wr && (magic == `IOTC_MAGIC_REQUEST);
  assign cmd_release  = cmd_wr && (magic == `IOTC_MAGIC_RELEASE);
  assign cmd_acq_ecl  = cmd_wr && (magic == `IOTC_MAGIC_ACQ_ECL);
  assign cmd_rel_ecl  = cmd_wr && (magic == `IOTC_MAGIC_REL_ECL);
  assign cmd_data_out = cmd_wr && (magic == `IOTC_MAGIC_DOUT);
  assign cmd_data_in  = cmd_wr && (magic == `IOTC_MAGIC_DIN);

  // Software-visible storage
  logic [0:12]       instr_q;
  logic [0:12]       instr_d;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;
  logic [DATA_W-1:0] din_q;
  logic [DATA_W-1:0] din_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // Sequencer and arbiter state
  iotc_pkg::iotc_state_t state_q;
  iotc_pkg::iotc_state_t state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       req_q;
  logic       req_d;
  logic       cpu_gnt_q;
  logic       cpu_gnt_d;
  logic       irq_gnt_q;
  logic       irq_gnt_d;
  logic       tie_q;
  logic       tie_d;
  logic       ecl_q;
  logic       ecl_d;
  logic       forced_q;
  logic       forced_d;
  logic [2:0] ffunc_q;
  logic [2:0] ffunc_d;
  logic [2:0] lfunc_q;
  logic [2:0] lfunc_d;
  logic       lines_q;
  logic       lines_d;
  logic       demand_q;
  logic       demand_d;

  // Operation decode from the instruction
  logic [2:0] op;
  logic       f1;
  logic       f2;
  logic       op_out;
  logic [0:8] disp;

  assign op   = instr_q[10:12];
  assign f1   = !instr_q[10];
  assign f2   = instr_q[10] || (!instr_q[10] && !instr_q[11]);
  // Block output, data output and conditions output drive the data lines
  assign op_out = (op == 3'h2) || (op == 3'h3) || (op == 3'h4);

  // Dispatch address: opcode group on top, device bits 3-5 in the middle
  always_comb begin
    disp      = '0;
    disp[0:2] = `IOTC_DISP_TOP;
    disp[3:5] = instr_q[3:5];
    disp[6:8] = instr_q[10:12];
  end

  // Arbiter: equal standing, earlier request wins, ties alternate
  logic cpu_want;
  logic irq_want;
  assign cpu_want = req_q;
  assign irq_want = interrupt_bus_request_i && !ecl_q;

  always_comb begin
    cpu_gnt_d = cpu_gnt_q;
    irq_gnt_d = irq_gnt_q;
    tie_d     = tie_q;
    ecl_d     = ecl_q;
    // Interrupt holds the bus only while it keeps asking
    if (irq_gnt_q && !interrupt_bus_request_i) begin
      irq_gnt_d = 1'b0;
    end
    if (!cpu_gnt_q && !irq_gnt_q) begin
      if (cpu_want && irq_want) begin
        cpu_gnt_d = !tie_q;
        irq_gnt_d = tie_q;
        tie_d     = !tie_q;
      end else if (cpu_want) begin
        cpu_gnt_d = 1'b1;
      end else if (irq_want) begin
        irq_gnt_d = 1'b1;
      end
    end
    // ECL acquisition takes the grant from the interrupt side and blocks new ones
    if (cmd_acq_ecl) begin
      ecl_d     = 1'b1;
      irq_gnt_d = 1'b0;
    end else if (cmd_rel_ecl) begin
      ecl_d = 1'b0;
    end
    if (cmd_release) begin
      cpu_gnt_d = 1'b0;
    end
  end

  // Sequencer: request, set up lines, demand, wait transfer, drop
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    req_d    = req_q;
    forced_d = forced_q;
    ffunc_d  = ffunc_q;
    lfunc_d  = lfunc_q;
    lines_d  = lines_q;
    demand_d = demand_q;
    din_d    = din_q;
    unique case (state_q)
      iotc_pkg::ST_IDLE: begin
        if (cmd_request || cmd_data_out || cmd_data_in) begin
          req_d    = 1'b1;
          forced_d = cmd_data_out || cmd_data_in;
          ffunc_d  = cmd_data_out ? `IOTC_FUNC_DOUT : `IOTC_FUNC_DIN;
          state_d  = iotc_pkg::ST_WAIT;
        end
      end
      iotc_pkg::ST_WAIT: begin
        // No step is taken until the processor holds the bus
        if (cpu_gnt_q) begin
          req_d   = 1'b0;
          lines_d = 1'b1;
          lfunc_d = {1'b0, f1, f2};
          cnt_d   = 8'(SETUP_CYC);
          state_d = iotc_pkg::ST_SETUP;
        end
      end
      iotc_pkg::ST_SETUP: begin
        // Let the select and function lines settle at the device
        if (cnt_q > 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          demand_d = 1'b1;
          cnt_d    = 8'(DEMAND_CYC);
          state_d  = iotc_pkg::ST_DEMAND;
        end
      end
      iotc_pkg::ST_DEMAND: begin
        if (cnt_q > 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          state_d = iotc_pkg::ST_XFER;
        end
      end
      iotc_pkg::ST_XFER: begin
        if (transfer_i) begin
          if (forced_q ? (ffunc_q == `IOTC_FUNC_DIN) : !op_out) begin
            din_d = data_i;
          end
          demand_d = 1'b0;
          cnt_d    = 8'(HOLD_CYC);
          state_d  = iotc_pkg::ST_DROP;
        end
      end
      iotc_pkg::ST_DROP: begin
        // Lines stay up after demand falls to avoid misselection
        if (cnt_q > 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          lines_d = 1'b0;
          state_d = iotc_pkg::ST_DONE;
        end
      end
      iotc_pkg::ST_DONE: begin
        if (cmd_release) begin
          forced_d = 1'b0;
          state_d  = iotc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = iotc_pkg::ST_IDLE;
      end
    endcase
  end

  // Register writes
  always_comb begin
    instr_d = instr_q;
    dout_d  = dout_q;
    if (reg_wr_i && (reg_addr_i == `IOTC_OFS_INSTR)) begin
      instr_d = reg_wdata_i[12:0];
    end
    if (reg_wr_i && (reg_addr_i == `IOTC_OFS_DATA_OUT)) begin
      dout_d = reg_wdata_i;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `IOTC_OFS_INSTR:    rdata_d[12:0] = instr_q;
        `IOTC_OFS_DATA_OUT: rdata_d = dout_q;
        `IOTC_OFS_DATA_IN:  rdata_d = din_q;
        `IOTC_OFS_STATUS: begin
          rdata_d[`IOTC_ST_CPU_GRANT] = cpu_gnt_q;
          rdata_d[`IOTC_ST_IRQ_GRANT] = irq_gnt_q;
          rdata_d[`IOTC_ST_DEMAND]    = demand_q;
          rdata_d[`IOTC_ST_BUSY]      =
            (state_q != iotc_pkg::ST_IDLE) && (state_q != iotc_pkg::ST_DONE);
          rdata_d[`IOTC_ST_ECL_HELD]  = ecl_q;
          rdata_d[`IOTC_ST_DONE]      = (state_q == iotc_pkg::ST_DONE);
        end
        `IOTC_OFS_DISPATCH: rdata_d[8:0] = disp;
        default:            rdata_d = '0;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_q   <= iotc_pkg::ST_IDLE;
      cnt_q     <= 8'h00;
      req_q     <= 1'b0;
      cpu_gnt_q <= 1'b0;
      irq_gnt_q <= 1'b0;
      tie_q     <= 1'b0;
      ecl_q     <= 1'b0;
      forced_q  <= 1'b0;
      ffunc_q   <= 3'h0;
      lfunc_q   <= 3'h0;
      lines_q   <= 1'b0;
      demand_q  <= 1'b0;
      instr_q   <= 13'h0000;
      dout_q    <= '0;
      din_q     <= '0;
      rdata_q   <= '0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      req_q     <= req_d;
      cpu_gnt_q <= cpu_gnt_d;
      irq_gnt_q <= irq_gnt_d;
      tie_q     <= tie_d;
      ecl_q     <= ecl_d;
      forced_q  <= forced_d;
      ffunc_q   <= ffunc_d;
      lfunc_q   <= lfunc_d;
      lines_q   <= lines_d;
      demand_q  <= demand_d;
      instr_q   <= instr_d;
      dout_q    <= dout_d;
      din_q     <= din_d;
      rdata_q   <= rdata_d;
    end
  end

  // Outputs: select and function lines only while the lines are held
  always_comb begin
    bus_ctl_o = '0;
    if (lines_q) begin
      bus_ctl_o.controller_select_lines = instr_q[3:9];
      bus_ctl_o.function_line_0 = 1'b0;
      bus_ctl_o.function_line_1 = forced_q ? ffunc_q[1] : lfunc_q[1];
      bus_ctl_o.function_line_2 = forced_q ? ffunc_q[0] : lfunc_q[0];
    end
    bus_ctl_o.demand = demand_q;
  end

  assign reg_rdata_o             = rdata_q;
  assign processor_bus_request_o = req_q;
  assign processor_bus_grant_o   = cpu_gnt_q;
  assign interrupt_bus_grant_o   = irq_gnt_q;
  assign bus_return_o            = ecl_q;
  assign data_o                  = dout_q;
  // Data drive only while lines are up for an output operation
  assign data_oe_o = lines_q &&
    (forced_q ? (ffunc_q == `IOTC_FUNC_DOUT) : op_out);

endmodule : iotc_io_bus_ctl

// ===== test/iotc_io_bus_ctl_assertions.sv
// Checker: port-level assertions for the I/O bus transfer control
`timescale 1ns/1ns
`include "iotc_consts.svh"
module iotc_io_bus_ctl_chk #(
  parameter int DATA_W = 36
) (
  input wire logic                    clk_sys_i,
  input wire logic                    srst_i,
  input wire logic [7:0]              reg_addr_i,
  input wire logic [DATA_W-1:0]       reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    interrupt_bus_request_i,
  input wire logic                    interrupt_bus_grant_o,
  input wire logic                    processor_bus_request_o,
  input wire logic                    processor_bus_grant_o,
  input wire logic                    bus_return_o,
  input wire iotc_pkg::iotc_bus_ctl_t bus_ctl_o,
  input wire logic                    transfer_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  logic       cmd_wr;
  logic [8:0] magic;
  logic       idle;
  // Command decode; idle means no processor request and no processor grant outstanding
  assign cmd_wr = reg_wr_i && reg_addr_i == `IOTC_OFS_CMD &&
                  reg_wdata_i[`IOTC_CMD_COND_BIT];
  assign magic  = reg_wdata_i[8:0];
  assign idle   = !processor_bus_request_o && !processor_bus_grant_o;

  a_request_raise: assert property (
    cmd_wr && magic == `IOTC_MAGIC_REQUEST && idle
    |=> processor_bus_request_o) else $error("no bus request");
  a_no_condition: assert property (
    reg_wr_i && !reg_wdata_i[15] && idle |=> !processor_bus_request_o)
    else $error("request w/o cond");
  a_grant_exclusive: assert property (
    !(processor_bus_grant_o && interrupt_bus_grant_o))
    else $error("both grants set");
  a_irq_drop: assert property (
    !interrupt_bus_request_i |=> !interrupt_bus_grant_o)
    else $error("irq grant kept");
  a_grant_free: assert property (
    $rose(processor_bus_grant_o) |-> !$past(interrupt_bus_grant_o))
    else $error("grant taken");
  a_demand_grant: assert property (
    bus_ctl_o.demand |-> processor_bus_grant_o)
    else $error("demand w/o grant");
  a_f0_quiet: assert property (
    processor_bus_grant_o |-> !bus_ctl_o.function_line_0)
    else $error("line 0 driven");
  a_func_any: assert property (
    bus_ctl_o.demand |->
    (bus_ctl_o.function_line_1 || bus_ctl_o.function_line_2))
    else $error("no function line");
  a_demand_hold: assert property (
    bus_ctl_o.demand && !transfer_i |=> bus_ctl_o.demand)
    else $error("demand dropped early");
  a_demand_drop: assert property (
    $fell(bus_ctl_o.demand) |-> $past(transfer_i))
    else $error("demand fell w/o xfer");
  // Select lines are bits 10 to 4, function lines 3 to 1, demand bit 0
  a_lines_after: assert property (
    $fell(bus_ctl_o.demand) |-> $stable(bus_ctl_o[10:1]) [*8])
    else $error("lines dropped");
  a_release_gnt: assert property (
    cmd_wr && magic == `IOTC_MAGIC_RELEASE |-> ##[1:2] !processor_bus_grant_o)
    else $error("grant kept");
  a_ecl_take: assert property (
    cmd_wr && magic == `IOTC_MAGIC_ACQ_ECL
    |=> ##[0:1] bus_return_o && !interrupt_bus_grant_o)
    else $error("segment not taken");
endmodule : iotc_io_bus_ctl_chk

bind iotc_io_bus_ctl iotc_io_bus_ctl_chk #(.DATA_W(DATA_W)) u_chk (
  .clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .interrupt_bus_request_i, .interrupt_bus_grant_o, .processor_bus_request_o,
  .processor_bus_grant_o, .bus_return_o, .bus_ctl_o, .transfer_i);

// ===== test/iotc_dev_model.sv
// Device controller model that answers demand with transfer
`timescale 1ns/1ns
module iotc_dev_model (
  input  wire logic                    clk_sys_i,
  input  wire logic                    srst_i,
  input  wire iotc_pkg::iotc_bus_ctl_t bus_ctl_i,
  input  wire logic [7:0]              delay_i,
  input  wire logic [35:0]             word_i,
  output      logic                    transfer_o,
  output      logic [35:0]             data_o
);
  logic [7:0] cnt_q;
  // Answer delay_i cycles into demand; hold transfer until demand falls
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_q      <= 8'h00;
      transfer_o <= 1'b0;
      data_o     <= 36'h0;
    end else if (!bus_ctl_i.demand) begin
      cnt_q      <= 8'h00;
      transfer_o <= 1'b0;
      data_o     <= ~data_o; // Released lines must not hold the last word
    end else if (cnt_q == delay_i) begin
      transfer_o <= 1'b1;
      data_o     <= word_i;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : iotc_dev_model

// ===== test/tb_top.sv
// Testbench: register-driven I/O transfers against a device model
`timescale 1ns/1ns
`include "iotc_consts.svh"
module tb_top;
  logic                    clk_sys_i;
  logic                    srst_i;
  logic [7:0]              ra;
  logic [35:0]             wd;
  logic                    wr_s;
  logic                    rd_s;
  logic [35:0]             rdata;
  logic                    irq_req;
  logic                    irq_gnt;
  logic                    cpu_req;
  logic                    cpu_gnt;
  logic                    ret;
  iotc_pkg::iotc_bus_ctl_t ctl;
  logic                    xfer;
  logic [35:0]             din;
  logic [35:0]             dout;
  logic                    oe;
  logic [7:0]              dly;
  logic [35:0]             word;
  logic [35:0]             v;
  logic [6:0]              dev;
  int                      fail_count;
  int                      comparisons;

  // 100 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  iotc_io_bus_ctl uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata), .interrupt_bus_request_i(irq_req),
    .interrupt_bus_grant_o(irq_gnt), .processor_bus_request_o(cpu_req),
    .processor_bus_grant_o(cpu_gnt), .bus_return_o(ret), .bus_ctl_o(ctl),
    .transfer_i(xfer), .data_i(din), .data_o(dout), .data_oe_o(oe));

  iotc_dev_model u_dev (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .bus_ctl_i(ctl), .delay_i(dly), .word_i(word), .transfer_o(xfer),
    .data_o(din));

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [35:0] d);
    @(posedge clk_sys_i);
    ra   <= a;
    wd   <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_i);
    wr_s <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [35:0] d);
    @(posedge clk_sys_i);
    ra   <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick

  // Bounded wait on demand; a hang ends the run
  task automatic wait_dem(input logic lvl);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
      if (n > 300) begin
        fail_count++;
        final_report();
      end
    end while (ctl.demand !== lvl);
  endtask : wait_dem

  // Handshake, line hold, status, input data and release of one transfer
  task automatic finish_op(input logic f1, input logic f2, input logic o,
                           input logic inp);
    wait_dem(1'b1);
    chk(ctl, {dev, 1'b0, f1, f2, 1'b1});
    chk(oe, o);
    wait_dem(1'b0);
    chk(ctl, {dev, 1'b0, f1, f2, 1'b0});
    tick(12);
    chk(ctl, 36'h0);
    rd(`IOTC_OFS_STATUS, v);
    chk(v & 36'h21, 36'h21);
    if (inp) begin
      rd(`IOTC_OFS_DATA_IN, v);
      chk(v, word);
    end
    wr(`IOTC_OFS_CMD, 36'h80c0);
    tick(1);
    chk(cpu_gnt, 1'b0);
  endtask : finish_op

  initial begin
    tick(50000);
    fail_count++;
    final_report();
  end

  initial begin
    srst_i = 1'b1;
    ra = 8'h00;
    wd = 36'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    irq_req = 1'b0;
    dly = 8'h00;
    word = 36'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    // Quiet after reset; unmapped read and write without condition
    rd(`IOTC_OFS_STATUS, v);
    chk({v[5:0], cpu_req, irq_gnt, ret, oe}, 36'h0);
    rd(8'h20, v);
    chk(v, 36'h0);
    wr(`IOTC_OFS_CMD, 36'h0100);
    tick(2);
    chk(cpu_req, 1'b0);
    $display("Test reset done");
    // All eight operation types, device answering promptly to slowly
    for (int op = 0; op < 8; op++) begin
      dev  = 7'h55 ^ 7'(op * 9);
      word = 36'h5a5a5a5a0 | 36'(op);
      dly  = 8'(op * 5);
      wr(`IOTC_OFS_INSTR, {26'h0, dev, op[2:0]});
      wr(`IOTC_OFS_DATA_OUT, ~word);
      rd(`IOTC_OFS_DISPATCH, v);
      chk(v, {27'h0, 3'h7, dev[6:4], op[2:0]});
      chk(dout, ~word);
      wr(`IOTC_OFS_CMD, 36'h8100);
      finish_op(~op[2], op[2] | ~op[1], op inside {2, 3, 4},
                !(op inside {2, 3, 4}));
    end
    $display("Test operation types done");
    // Interrupt side holds the bus; processor request must wait
    @(posedge clk_sys_i) irq_req <= 1'b1;
    tick(3);
    chk(irq_gnt, 1'b1);
    dev = 7'h2a;
    wr(`IOTC_OFS_INSTR, {26'h0, dev, 3'h1});
    wr(`IOTC_OFS_CMD, 36'h8100);
    tick(3);
    chk({cpu_req, cpu_gnt, ctl.demand}, 3'b100);
    @(posedge clk_sys_i) irq_req <= 1'b0;
    finish_op(1'b1, 1'b1, 1'b0, 1'b1);
    $display("Test arbitration done");
    // Stand-alone data-out then data-in functions
    for (int k = 0; k < 2; k++) begin
      wr(`IOTC_OFS_CMD, k[0] ? 36'h8018 : 36'h8014);
      finish_op(~k[0], 1'b1, ~k[0], k[0]);
    end
    $display("Test data functions done");
    // Segment acquisition preempts the interrupt side until released
    @(posedge clk_sys_i) irq_req <= 1'b1;
    tick(3);
    wr(`IOTC_OFS_CMD, 36'h8001);
    tick(2);
    chk({ret, irq_gnt}, 2'b10);
    wr(`IOTC_OFS_CMD, 36'h8002);
    tick(3);
    chk({ret, irq_gnt}, 2'b01);
    @(posedge clk_sys_i) irq_req <= 1'b0;
    $display("Test segment done");
    final_report();
  end
endmodule : tb_top
